/* core/fad_decoder.sv */
// Function
// - byte 9E stores AH into low flags, 3 clocks in every mode.
// - byte F9 sets carry flag, 2 clocks in every mode.
// - byte FD sets direction flag, 2 clocks in every mode.
// - byte FB sets interrupt enable, 8 clocks, privilege checked when protected.
// - 000000dw with register-register addressing byte is sum, 2 clocks.
// - 0000001w with memory addressing byte adds memory into register, 6 clocks.
// - 100000sw select 000 adds immediate, 2 clocks register, 7 memory.
// - 000100dw register-register is carry sum, 2 clocks.
// - 0001000w adds register plus carry into memory, 7 clocks.
// - 0001001w adds memory plus carry into register, 6 clocks.
// - 100000sw select 010 adds immediate plus carry, 2 register, 7 memory.
// - 1111111w select 000 increments, 2 clocks register, 6 memory.
// - 001010dw register-register is difference, 2 clocks.
// - 0000010w and 0001010w take immediate without addressing byte, 2 clocks.
module fad_decoder (
  input wire logic clk,                          // 40 MHz clock
  input wire logic rst,                          // synchronous reset, high
  input wire fad_pkg::fad_apb_req_t apb_req,     // apb request from master
  output fad_pkg::fad_apb_rsp_t apb_rsp,         // apb answer, registered
  output logic exec_busy,                        // instruction in execution
  output fad_pkg::fad_op_t exec_op               // operation last decoded
);
  import fad_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    fad_state_t fsm;
    logic [31:0] insn;
    fad_dec_t dec;
    logic [15:0] flags;
    logic [15:0] saved;
    logic [3:0] count;
    logic done;
    fad_apb_rsp_t rsp;
  } fad_core_t;

  fad_core_t s;
  fad_core_t next_s;

  // ****************************************************************
  // decode
  // ****************************************************************
  // maps opcode, addressing byte and mode onto an operation and cost
  function automatic fad_dec_t fad_decode(input logic [31:0] w);
    fad_dec_t d;
    logic [7:0] opc;
    logic [7:0] mrm;
    logic is_mem;
    d = '0;
    opc = w[INSN_OPC_LSB +: 8];
    mrm = w[INSN_MODRM_LSB +: 8];
    is_mem = (mrm[7:6] != MOD_REG);
    d.op = OP_NONE;
    d.clocks = CLK_UNKNOWN;
    if (opc == OPC_STORE_AH) begin
      d.op = OP_STORE_AH;
      d.clocks = CLK_STORE_AH;
      d.known = 1'b1;
    end else if (opc == OPC_SET_CARRY) begin
      d.op = OP_SET_CARRY;
      d.clocks = CLK_SET_FLAG;
      d.known = 1'b1;
    end else if (opc == OPC_SET_DIR) begin
      d.op = OP_SET_DIR;
      d.clocks = CLK_SET_FLAG;
      d.known = 1'b1;
    end else if (opc == OPC_SET_IE) begin
      d.op = OP_SET_IE;
      d.clocks = CLK_SET_IE;
      d.priv_fault = w[INSN_PROT_BIT] & ~w[INSN_PRIV_BIT];
      d.known = 1'b1;
    end else if (opc == OPC_FLAGS_SAVE) begin
      d.op = OP_FLAGS_SAVE;
      d.clocks = CLK_SAVE;
      d.known = 1'b1;
    end else if (opc == OPC_FLAGS_RESTORE) begin
      d.op = OP_FLAGS_RESTORE;
      d.clocks = CLK_RESTORE;
      d.known = 1'b1;
    end else if (opc[7:1] == PAT_SUM_ACC || opc[7:1] == PAT_CSUM_ACC) begin
      // short accumulator forms: immediate follows the opcode directly
      d.op = (opc[7:1] == PAT_SUM_ACC) ? OP_SUM : OP_CARRY_SUM;
      d.clocks = CLK_REG;
      d.wide = opc[0];
      d.has_imm = 1'b1;
      d.known = 1'b1;
    end else if (opc[7:2] == PAT_SUM_RM || opc[7:2] == PAT_CSUM_RM ||
                 opc[7:2] == PAT_DIFF_RM) begin
      // register/memory forms with an addressing byte
      if (opc[7:2] == PAT_SUM_RM) begin
        d.op = OP_SUM;
      end else if (opc[7:2] == PAT_CSUM_RM) begin
        d.op = OP_CARRY_SUM;
      end else begin
        d.op = OP_DIFFERENCE;
      end
      d.wide = opc[0];
      d.dir = opc[1];
      d.has_modrm = 1'b1;
      d.mem = is_mem;
      d.known = 1'b1;
      if (!is_mem) begin
        d.clocks = CLK_REG;
      end else if (opc[1]) begin
        d.clocks = CLK_MEM_SRC;
      end else begin
        d.clocks = CLK_MEM_DST;
      end
    end else if (opc[7:2] == PAT_IMM_GRP) begin
      // immediate group: select field picks the operation
      d.wide = opc[0];
      d.sext = opc[1];
      d.has_modrm = 1'b1;
      d.has_imm = 1'b1;
      d.mem = is_mem;
      d.clocks = is_mem ? CLK_MEM_DST : CLK_REG;
      if (mrm[5:3] == SEL_SUM) begin
        d.op = OP_SUM;
        d.known = 1'b1;
      end else if (mrm[5:3] == SEL_CSUM) begin
        d.op = OP_CARRY_SUM;
        d.known = 1'b1;
      end else begin
        d.clocks = CLK_UNKNOWN;
      end
    end else if (opc[7:1] == PAT_INC_GRP && mrm[5:3] == SEL_INC) begin
      d.op = OP_PLUS_ONE;
      d.wide = opc[0];
      d.has_modrm = 1'b1;
      d.mem = is_mem;
      d.clocks = is_mem ? CLK_INC_MEM : CLK_REG;
      d.known = 1'b1;
    end else if (opc[7:3] == PAT_INC_SHORT) begin
      // register short form, register coded in the low three bits
      d.op = OP_PLUS_ONE;
      d.wide = 1'b1;
      d.clocks = CLK_REG;
      d.known = 1'b1;
    end
    return d;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  // apb slave, execution countdown and flag effects
  always_comb begin
    logic [7:0] addr;
    logic wr_acc;
    logic insn_hit;
    logic stall;
    logic [15:0] fl;
    fad_dec_t nd;
    addr = apb_req.paddr;
    wr_acc = apb_req.psel & apb_req.penable & s.rsp.pready & apb_req.pwrite;
    insn_hit = (addr == ADDR_INSN);
    stall = apb_req.pwrite & insn_hit & (s.fsm == ST_EXEC);
    fl = s.flags;
    nd = fad_decode(apb_req.pwdata);
    next_s = s;

    // execution: count down, apply the flag effect on the last clock
    case (s.fsm)
      ST_IDLE: begin
        next_s.fsm = ST_IDLE;
      end
      ST_EXEC: begin
        if (s.count == 4'h1) begin
          next_s.fsm = ST_IDLE;
          next_s.done = 1'b1;
          case (s.dec.op)
            OP_STORE_AH: begin
              fl[7:0] = (s.flags[7:0] & ~AH_MASK) |
                        (s.insn[INSN_AH_LSB +: 8] & AH_MASK);
            end
            OP_SET_CARRY: begin
              fl[FLG_CF] = 1'b1;
            end
            OP_SET_DIR: begin
              fl[FLG_DF] = 1'b1;
            end
            OP_SET_IE: begin
              if (!s.dec.priv_fault) begin
                fl[FLG_IF] = 1'b1;
              end
            end
            OP_FLAGS_RESTORE: begin
              fl = s.saved;
            end
            default: begin
              fl = s.flags;
            end
          endcase
          next_s.flags = fl;
          if (s.dec.op == OP_FLAGS_SAVE) begin
            next_s.saved = s.flags;
          end
        end else begin
          next_s.count = s.count - 4'h1;
        end
      end
      default: begin
        next_s.fsm = ST_IDLE;
      end
    endcase

    // register writes take effect at the completing access edge
    if (wr_acc) begin
      if (addr == ADDR_INSN) begin
        next_s.insn = apb_req.pwdata;
        next_s.dec = nd;
        next_s.count = nd.clocks;
        next_s.done = 1'b0;
        next_s.fsm = ST_EXEC;
      end else if (addr == ADDR_FLAGS) begin
        next_s.flags = apb_req.pwdata[15:0];
      end else if (addr == ADDR_SAVED) begin
        next_s.saved = apb_req.pwdata[15:0];
      end
    end

    // answer: no wait state, longer while an instruction write stalls
    next_s.rsp.pready = 1'b0;
    next_s.rsp.pslverr = 1'b0;
    if (apb_req.psel && !s.rsp.pready && !stall) begin
      next_s.rsp.pready = 1'b1;
      next_s.rsp.prdata = 32'h0000_0000;
      if (addr == ADDR_INSN) begin
        next_s.rsp.prdata = s.insn;
      end else if (addr == ADDR_RESULT) begin
        next_s.rsp.prdata = {14'h0000, s.done, s.fsm == ST_EXEC, s.dec};
      end else if (addr == ADDR_FLAGS) begin
        next_s.rsp.prdata = {16'h0000, s.flags};
      end else if (addr == ADDR_SAVED) begin
        next_s.rsp.prdata = {16'h0000, s.saved};
      end else begin
        next_s.rsp.pslverr = 1'b1;
      end
    end else if (s.rsp.pready) begin
      next_s.rsp.prdata = s.rsp.prdata;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // state update with synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      s.fsm <= ST_IDLE;
      s.insn <= INSN_RST;
      s.dec <= '0;
      s.flags <= FLAGS_RST;
      s.saved <= FLAGS_RST;
      s.count <= 4'h0;
      s.done <= 1'b0;
      s.rsp <= '0;
      exec_busy <= 1'b0;
      exec_op <= OP_NONE;
    end else begin
      s <= next_s;
      exec_busy <= (next_s.fsm == ST_EXEC);
      exec_op <= next_s.dec.op;
    end
  end

  // outputs straight from flip-flops
  assign apb_rsp = s.rsp;

endmodule

/* core/fad_pkg.sv */
package fad_pkg;

  // ****************************************************************
  // bus geometry and register map
  // ****************************************************************
  localparam int APB_AW = 8;
  localparam logic [7:0] ADDR_INSN = 8'h00;    // instruction word, r/w
  localparam logic [7:0] ADDR_RESULT = 8'h04;  // decode result, read only
  localparam logic [7:0] ADDR_FLAGS = 8'h08;   // modelled flags, r/w
  localparam logic [7:0] ADDR_SAVED = 8'h0C;   // saved flags copy, r/w

  // instruction word field positions
  localparam int INSN_OPC_LSB = 0;
  localparam int INSN_MODRM_LSB = 8;
  localparam int INSN_AH_LSB = 16;
  localparam int INSN_PROT_BIT = 24;
  localparam int INSN_PRIV_BIT = 25;
  localparam logic [31:0] INSN_RST = 32'h0000_0000;

  // result word status bit positions above the decode fields
  localparam int RES_BUSY_BIT = 16;
  localparam int RES_DONE_BIT = 17;

  // ****************************************************************
  // opcode patterns
  // ****************************************************************
  localparam logic [7:0] OPC_STORE_AH = 8'h9E;
  localparam logic [7:0] OPC_SET_CARRY = 8'hF9;
  localparam logic [7:0] OPC_SET_DIR = 8'hFD;
  localparam logic [7:0] OPC_SET_IE = 8'hFB;
  localparam logic [7:0] OPC_FLAGS_SAVE = 8'h9C;
  localparam logic [7:0] OPC_FLAGS_RESTORE = 8'h9D;
  localparam logic [5:0] PAT_SUM_RM = 6'h00;      // 000000dw
  localparam logic [5:0] PAT_CSUM_RM = 6'h04;     // 000100dw
  localparam logic [5:0] PAT_DIFF_RM = 6'h0A;     // 001010dw
  localparam logic [5:0] PAT_IMM_GRP = 6'h20;     // 100000sw
  localparam logic [6:0] PAT_SUM_ACC = 7'h02;     // 0000010w
  localparam logic [6:0] PAT_CSUM_ACC = 7'h0A;    // 0001010w
  localparam logic [6:0] PAT_INC_GRP = 7'h7F;     // 1111111w
  localparam logic [4:0] PAT_INC_SHORT = 5'h08;   // 01000 reg
  localparam logic [2:0] SEL_SUM = 3'h0;
  localparam logic [2:0] SEL_CSUM = 3'h2;
  localparam logic [2:0] SEL_INC = 3'h0;
  localparam logic [1:0] MOD_REG = 2'h3;

  // ****************************************************************
  // execution clock counts
  // ****************************************************************
  localparam logic [3:0] CLK_STORE_AH = 4'h3;
  localparam logic [3:0] CLK_SET_FLAG = 4'h2;
  localparam logic [3:0] CLK_SET_IE = 4'h8;
  localparam logic [3:0] CLK_SAVE = 4'h4;
  localparam logic [3:0] CLK_RESTORE = 4'h5;
  localparam logic [3:0] CLK_REG = 4'h2;
  localparam logic [3:0] CLK_MEM_SRC = 4'h6;
  localparam logic [3:0] CLK_MEM_DST = 4'h7;
  localparam logic [3:0] CLK_INC_MEM = 4'h6;
  localparam logic [3:0] CLK_UNKNOWN = 4'h1;

  // ****************************************************************
  // flags layout
  // ****************************************************************
  localparam int FLG_CF = 0;
  localparam int FLG_IF = 9;
  localparam int FLG_DF = 10;
  localparam logic [15:0] FLAGS_RST = 16'h0002;
  localparam logic [7:0] AH_MASK = 8'hD5;  // sign, zero, aux, parity, carry

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_STORE_AH = 4'h1,
    OP_SET_CARRY = 4'h2,
    OP_SET_DIR = 4'h3,
    OP_SET_IE = 4'h4,
    OP_FLAGS_SAVE = 4'h5,
    OP_FLAGS_RESTORE = 4'h6,
    OP_SUM = 4'h7,
    OP_CARRY_SUM = 4'h8,
    OP_PLUS_ONE = 4'h9,
    OP_DIFFERENCE = 4'hA
  } fad_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } fad_state_t;

  typedef struct packed {
    fad_op_t op;
    logic [3:0] clocks;
    logic wide;
    logic dir;
    logic sext;
    logic has_modrm;
    logic has_imm;
    logic mem;
    logic priv_fault;
    logic known;
  } fad_dec_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } fad_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fad_apb_rsp_t;

endpackage

/* tb/fad_chk.sv */
module fad_chk (
  input wire logic clk,                       // clock
  input wire logic rst,                       // synchronous reset
  input wire fad_pkg::fad_apb_req_t apb_req,  // apb request
  input wire fad_pkg::fad_apb_rsp_t apb_rsp,  // apb answer
  input wire logic exec_busy,                 // execution busy
  input wire fad_pkg::fad_op_t exec_op        // last operation
);
  import fad_pkg::*;
  logic insn_wr;
  // ****************
  // helper logic
  // ****************
  // completed write to the instruction word
  assign insn_wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
    && apb_req.paddr == ADDR_INSN;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****************
  // properties
  // ****************
  a_busy_span: assert property ($rose(exec_busy) |-> ##[1:8] !exec_busy)
    else $error("execution longer than eight clocks");
  a_store_ah_len: assert property ($rose(exec_busy) && exec_op == OP_STORE_AH
    |-> exec_busy [*3] ##1 !exec_busy) else $error("store ah length wrong");
  a_set_ie_len: assert property ($rose(exec_busy) && exec_op == OP_SET_IE
    |-> exec_busy [*8] ##1 !exec_busy) else $error("set interrupt length wrong");
  a_set_flag_len: assert property ($rose(exec_busy)
    && (exec_op == OP_SET_CARRY || exec_op == OP_SET_DIR)
    |-> exec_busy [*2] ##1 !exec_busy) else $error("set flag length wrong");
  a_busy_cause: assert property ($rose(exec_busy) |-> $past(insn_wr))
    else $error("execution without instruction write");
  a_op_cause: assert property (!$stable(exec_op) |-> $past(insn_wr))
    else $error("operation changed without instruction write");
  a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
    else $error("error answer malformed");
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready longer than one cycle");
  a_read_prompt: assert property (apb_req.psel && !apb_req.penable && !apb_req.pwrite
    |=> apb_rsp.pready) else $error("read not answered at once");
  a_insn_wait: assert property (exec_busy && apb_req.psel && apb_req.penable && apb_req.pwrite
    && apb_req.paddr == ADDR_INSN |-> !apb_rsp.pready) else $error("write taken while busy");
endmodule

bind fad_decoder fad_chk i_chk (
  .clk(clk),
  .rst(rst),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .exec_busy(exec_busy),
  .exec_op(exec_op)
);

/* tb/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fad_pkg::*;
  `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
    $display("Error at %0t got %h expected %h", $time, a, b); end end
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} fad_exp_t;
  typedef struct packed {logic [31:0] w; fad_op_t op; logic [3:0] c; logic [7:0] f;} fad_case_t;
  localparam fad_case_t CASES [23] = '{
    '{32'h0000_00F9, OP_SET_CARRY, 4'h2, 8'h01}, '{32'h0000_00FD, OP_SET_DIR, 4'h2, 8'h01},
    '{32'h0100_00FB, OP_SET_IE, 4'h8, 8'h03}, '{32'h0300_00FB, OP_SET_IE, 4'h8, 8'h01},
    '{32'h0000_009C, OP_FLAGS_SAVE, 4'h4, 8'h01}, '{32'h0000_009E, OP_STORE_AH, 4'h3, 8'h01},
    '{32'h0000_C000, OP_SUM, 4'h2, 8'h11}, '{32'h0000_0503, OP_SUM, 4'h6, 8'hD5},
    '{32'h0000_0501, OP_SUM, 4'h7, 8'h95}, '{32'h0000_C081, OP_SUM, 4'h2, 8'h99},
    '{32'h0000_0583, OP_SUM, 4'h7, 8'hBD}, '{32'h0000_C012, OP_CARRY_SUM, 4'h2, 8'h51},
    '{32'h0000_0510, OP_CARRY_SUM, 4'h7, 8'h15}, '{32'h0000_0513, OP_CARRY_SUM, 4'h6, 8'hD5},
    '{32'h0000_D083, OP_CARRY_SUM, 4'h2, 8'hB9}, '{32'h0000_1580, OP_CARRY_SUM, 4'h7, 8'h1D},
    '{32'h0000_C0FF, OP_PLUS_ONE, 4'h2, 8'h91}, '{32'h0000_05FE, OP_PLUS_ONE, 4'h6, 8'h15},
    '{32'h0000_C02A, OP_DIFFERENCE, 4'h2, 8'h51}, '{32'h0000_0005, OP_SUM, 4'h2, 8'h89},
    '{32'h0000_0014, OP_CARRY_SUM, 4'h2, 8'h09}, '{32'h0000_009D, OP_FLAGS_RESTORE, 4'h5, 8'h01},
    '{32'h0000_000F, OP_NONE, 4'h1, 8'h00}};
  logic clk;
  logic rst;
  fad_apb_req_t apb_req;
  fad_apb_rsp_t apb_rsp;
  logic exec_busy;
  fad_op_t exec_op;
  fad_exp_t q[$];
  fad_exp_t x;
  fad_case_t t;
  int miscompares;
  int check_count;
  logic [15:0] fl;
  logic [15:0] sv;
  logic [31:0] w;
  logic [31:0] r;
  logic [4:0] n;
  logic [7:0] m;

  fad_decoder i_fad_decoder (
    .clk(clk),              // clock
    .rst(rst),              // reset
    .apb_req(apb_req),      // apb request
    .apb_rsp(apb_rsp),      // apb answer
    .exec_busy(exec_busy),  // busy
    .exec_op(exec_op)       // operation
  );

  // ****************
  // bus cycle and completion
  // ****************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, mk, ed,
                     input logic e);
    int k = 0;
    q.push_back('{ed, mk, e});
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    // hold the access phase until ready is sampled high at a rising edge
    do begin
      @(posedge clk);
      k++;
    end while (apb_rsp.pready !== 1'b1 && k < 40);
    if (apb_rsp.pready !== 1'b1) begin
      miscompares++;
    end
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  // counts cycles until execution ends
  task automatic wait_idle();
    n = 0;
    #1;
    while (exec_busy === 1'b1 && n < 5'h14) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // compares each bus answer with the oldest expectation at the completing edge
  always @(posedge clk) begin
    if (apb_rsp.pready === 1'b1 && apb_req.psel === 1'b1 && apb_req.penable === 1'b1) begin
      x = (q.size() > 0) ? q.pop_front() : '{32'h0, 32'h0, 1'bx};
      `CHK(apb_rsp.prdata & x.m, x.d)
      `CHK(apb_rsp.pslverr, x.e)
    end
  end

  // clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // watchdog
  initial begin
    #200000;
    miscompares++;
    test_done();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    apb_req = '0;
    miscompares = 0;
    check_count = 0;
    fl = 16'h0002;
    sv = 16'h0002;
    r = $urandom(91673);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_INSN, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b0);
    apb(1'b0, ADDR_RESULT, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b0);
    apb(1'b0, ADDR_FLAGS, 32'h0, 32'hFFFF_FFFF, 32'h0000_0002, 1'b0);
    apb(1'b0, ADDR_SAVED, 32'h0, 32'hFFFF_FFFF, 32'h0000_0002, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b1);
    apb(1'b1, 8'h14, 32'hFFFF_FFFF, 32'h0, 32'h0, 1'b1);
    apb(1'b1, ADDR_RESULT, 32'hFFFF_FFFF, 32'h0, 32'h0, 1'b0);
    apb(1'b0, ADDR_RESULT, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b0);
    for (int i = 0; i < 23; i++) begin
      t = CASES[i];
      r = $urandom;
      w = t.w | {8'h00, r[7:0], 5'h00, r[10:8], 8'h00};
      apb(1'b1, ADDR_INSN, w, 32'h0, 32'h0, 1'b0);
      wait_idle();
      `CHK(n, {1'b0, t.c})
      `CHK(exec_op, t.op)
      case (t.op)
        OP_SET_CARRY: fl[FLG_CF] = 1'b1;
        OP_SET_DIR: fl[FLG_DF] = 1'b1;
        OP_SET_IE: fl[FLG_IF] = fl[FLG_IF] | !t.f[1];
        OP_FLAGS_SAVE: sv = fl;
        OP_FLAGS_RESTORE: fl = sv;
        OP_STORE_AH: fl[7:0] = (fl[7:0] & ~AH_MASK) | (w[23:16] & AH_MASK);
        default: ;
      endcase
      m = 8'h1F | ((t.op >= OP_SUM) ? 8'h80 : 8'h00) | ((w[7:2] == PAT_IMM_GRP) ? 8'h20 : 8'h00);
      if (w[7:2] == PAT_SUM_RM || w[7:2] == PAT_CSUM_RM || w[7:2] == PAT_DIFF_RM) begin
        m = m | 8'h40;
      end
      apb(1'b0, ADDR_RESULT, 32'h0, {14'h0, 2'h3, 8'hFF, m},
          {14'h0, 2'h2, t.op, t.c, t.f & m}, 1'b0);
      apb(1'b0, ADDR_FLAGS, 32'h0, 32'hFFFF_FFFF, {16'h0, fl}, 1'b0);
    end
    apb(1'b0, ADDR_SAVED, 32'h0, 32'hFFFF_FFFF, {16'h0, sv}, 1'b0);
    // second instruction written while the first still runs
    apb(1'b1, ADDR_INSN, 32'h0000_00FB, 32'h0, 32'h0, 1'b0);
    apb(1'b1, ADDR_INSN, 32'h0000_00F9, 32'h0, 32'h0, 1'b0);
    wait_idle();
    `CHK(n, 5'h02)
    `CHK(exec_op, OP_SET_CARRY)
    test_done();
  end
endmodule
